// ### pkg/ccr_pkg.sv
// ccr_pkg: constants of the comparator control register bank
// assumes a 32-bit AHB-Lite register bus and one 25 MHz hclk domain
//
// Notes on behaviour
// - one register per channel pair; upper nibble odd, lower even, reset zero
// - channel bit 7 set inverts the odd comparator output
// - channel bit 5 turns odd comparator hysteresis off when set
// - channel bit 4 enables the odd comparator; clear holds output low
// - channel bit 3 set inverts the even comparator output
// - channel bit 1 turns even comparator hysteresis off when set
// - channel bit 0 enables the even comparator; clear forces output low
// - six bank registers, only bits 3, 1 and 0 stored, reset zero
// - bank bit 3 set inverts that comparator output
// - bank bit 1 turns that comparator hysteresis off when set
// - bank bit 0 enables that comparator; clear drives output low
// - bank bits 7:4 read back the last internal data bus value
// - each bank comparator raises an interrupt request when its output rises
package ccr_pkg;

  // =====================================================================
  // sizes
  localparam int unsigned CCR_NUM_CH_REG = 4;
  localparam int unsigned CCR_NUM_BANK = 6;
  localparam int unsigned CCR_NUM_REG = 10;
  localparam int unsigned CCR_NUM_CMP = 14;
  localparam int unsigned CCR_BANK_BASE = 8;
  localparam logic [3:0] CCR_BANK_FIRST = 4'h4;

  // =====================================================================
  // register indexes; byte address is four times the index
  localparam logic [9:0] CCR_IDX_CHANNEL_CMP_CTRL_0 = 10'h0C0;
  localparam logic [9:0] CCR_IDX_CHANNEL_CMP_CTRL_2 = 10'h0C1;
  localparam logic [9:0] CCR_IDX_CHANNEL_CMP_CTRL_4 = 10'h0C2;
  localparam logic [9:0] CCR_IDX_CHANNEL_CMP_CTRL_6 = 10'h0C3;
  localparam logic [9:0] CCR_IDX_BANK_CMP_CTRL_8 = 10'h0C4;
  localparam logic [9:0] CCR_IDX_BANK_CMP_CTRL_9 = 10'h0C5;
  localparam logic [9:0] CCR_IDX_BANK_CMP_CTRL_10 = 10'h0C6;
  localparam logic [9:0] CCR_IDX_BANK_CMP_CTRL_11 = 10'h0C7;
  localparam logic [9:0] CCR_IDX_BANK_CMP_CTRL_12 = 10'h0C8;
  localparam logic [9:0] CCR_IDX_BANK_CMP_CTRL_13 = 10'h0C9;

  // =====================================================================
  // field positions
  localparam int unsigned CCR_BIT_INV_ODD = 7;
  localparam int unsigned CCR_BIT_HOFF_ODD = 5;
  localparam int unsigned CCR_BIT_EN_ODD = 4;
  localparam int unsigned CCR_BIT_INV_EVEN = 3;
  localparam int unsigned CCR_BIT_HOFF_EVEN = 1;
  localparam int unsigned CCR_BIT_EN_EVEN = 0;
  localparam int unsigned CCR_BIT_INV = 3;
  localparam int unsigned CCR_BIT_HOFF = 1;
  localparam int unsigned CCR_BIT_EN = 0;

  // =====================================================================
  // masks and reset values
  localparam logic [7:0] CCR_CH_MASK = 8'hBB;
  localparam logic [7:0] CCR_BANK_MASK = 8'h0B;
  localparam logic [7:0] CCR_BANK_BUS_MASK = 8'hF0;
  localparam logic [7:0] CCR_REG_RST = 8'h00;
  localparam logic [7:0] CCR_BUS_RST = 8'h00;

  // =====================================================================
  // bus encodings
  localparam int unsigned CCR_HTRANS_ACTIVE_BIT = 1;
  localparam logic CCR_HRESP_OKAY = 1'b0;
  localparam logic [19:0] CCR_ADDR_HI_ZERO = 20'h00000;

endpackage : ccr_pkg

// ### logic/ccr_cmp_shape.sv
// ccr_cmp_shape: registered comparator output shaping and bank event pulses
// assumes control bits come straight from the register flops in hclk domain
`timescale 1ns/10ps
module ccr_cmp_shape
  import ccr_pkg::*;
#(
  parameter int unsigned N_CMP = CCR_NUM_CMP,
  parameter int unsigned N_BANK = CCR_NUM_BANK,
  parameter int unsigned BANK_BASE = CCR_BANK_BASE
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // controls and raw comparisons
  input wire logic [N_CMP-1:0] cmp_raw,
  input wire logic [N_CMP-1:0] cmp_inv,
  input wire logic [N_CMP-1:0] cmp_en,
  input wire logic [N_CMP-1:0] cmp_hoff,
  // shaped results
  output logic [N_CMP-1:0] cmp_out,
  output logic [N_CMP-1:0] cmp_hysteresis_off,
  output logic [N_BANK-1:0] bank_irq
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [N_CMP-1:0] out;
    logic [N_CMP-1:0] hoff;
    logic [N_BANK-1:0] irq;
  } ccr_shape_s;

  ccr_shape_s st_ff;
  ccr_shape_s nxt_st;
  logic [N_CMP-1:0] shaped;

  for (genvar i = 0; i < N_CMP; i++) begin : g_shape
    assign shaped[i] = (cmp_raw[i] ^ cmp_inv[i]) & cmp_en[i];
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.out = shaped;
    nxt_st.hoff = cmp_hoff;
    // rising edge of a bank output
    nxt_st.irq = shaped[BANK_BASE +: N_BANK] & ~st_ff.out[BANK_BASE +: N_BANK];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cmp_out = st_ff.out;
  assign cmp_hysteresis_off = st_ff.hoff;
  assign bank_irq = st_ff.irq;

  // =====================================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_bank_irq_rise;
    $rose(cmp_out[BANK_BASE]) |-> bank_irq[0];
  endproperty
  a_bank_irq_rise: assert property (p_bank_irq_rise) else $error("bank rise gave no event");

  property p_bank_irq_cause;
    bank_irq[0] |-> cmp_out[BANK_BASE] && !$past(cmp_out[BANK_BASE]);
  endproperty
  a_bank_irq_cause: assert property (p_bank_irq_cause) else $error("event without a rise");

  property p_disabled_low;
    !cmp_en[0] && cmp_inv[0] |=> !cmp_out[0];
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled output not low");

endmodule : ccr_cmp_shape

// ### logic/ccr_regs.sv
// ccr_regs: comparator control register bank on an AHB-Lite slave port
// assumes one master, single word transfers, hready fed back from hreadyout
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module ccr_regs
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // comparators
  input wire logic [CCR_NUM_CMP-1:0] cmp_raw,
  output logic [CCR_NUM_CMP-1:0] cmp_out,
  output logic [CCR_NUM_CMP-1:0] cmp_hysteresis_off,
  output logic [CCR_NUM_BANK-1:0] bank_irq
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [CCR_NUM_REG-1:0][7:0] regs;
    logic [7:0] internal_data_bus;
    logic wr_pend;
    logic [3:0] wr_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ccr_regs_s;

  localparam ccr_regs_s CCR_STATE_RST = '{
    regs: {CCR_NUM_REG{CCR_REG_RST}},
    internal_data_bus: CCR_BUS_RST,
    wr_pend: 1'b0,
    wr_idx: 4'h0,
    hrdata: 32'h00000000,
    hreadyout: 1'b1,
    hresp: CCR_HRESP_OKAY
  };

  ccr_regs_s st_ff;
  ccr_regs_s nxt_st;

  logic acc;
  logic hit;
  logic [9:0] widx;
  logic [3:0] ridx;
  logic [7:0] rd;
  logic [CCR_NUM_CMP-1:0] cmp_inv;
  logic [CCR_NUM_CMP-1:0] cmp_en;
  logic [CCR_NUM_CMP-1:0] cmp_hoff;

  // =====================================================================
  // field helpers
  function automatic logic [7:0] reg_mask(input logic [3:0] idx);
    logic [7:0] m;
    m = (idx < CCR_BANK_FIRST) ? CCR_CH_MASK : CCR_BANK_MASK;
    return m;
  endfunction : reg_mask

  function automatic logic [7:0] read_val(
    input logic [3:0] idx,
    input logic [CCR_NUM_REG-1:0][7:0] r,
    input logic [7:0] bus
  );
    logic [7:0] v;
    if (idx < CCR_BANK_FIRST) begin
      v = r[idx];
    end else begin
      v = (bus & CCR_BANK_BUS_MASK) | r[idx];
    end
    return v;
  endfunction : read_val

  // =====================================================================
  // address decode
  assign acc = hsel && hready && htrans[CCR_HTRANS_ACTIVE_BIT];
  assign widx = haddr[11:2];
  assign hit = (haddr[31:12] == CCR_ADDR_HI_ZERO) && (haddr[1:0] == 2'h0)
    && (widx >= CCR_IDX_CHANNEL_CMP_CTRL_0) && (widx <= CCR_IDX_BANK_CMP_CTRL_13);
  assign ridx = 4'(widx - CCR_IDX_CHANNEL_CMP_CTRL_0);

  // =====================================================================
  // register file and bus answer
  always_comb begin
    nxt_st = st_ff;
    rd = 8'h00;
    nxt_st.hreadyout = 1'b1;
    nxt_st.hresp = CCR_HRESP_OKAY;
    nxt_st.wr_pend = 1'b0;
    // data phase of a write; reserved bits never stored
    if (st_ff.wr_pend) begin
      nxt_st.regs[st_ff.wr_idx] = hwdata[7:0] & reg_mask(st_ff.wr_idx);
      nxt_st.internal_data_bus = hwdata[7:0];
    end
    if (acc && hit && hwrite) begin
      nxt_st.wr_pend = 1'b1;
      nxt_st.wr_idx = ridx;
    end
    nxt_st.hrdata = 32'h00000000;
    // read sees a write that completes in the same cycle
    if (acc && !hwrite && hit) begin
      rd = read_val(ridx, nxt_st.regs, nxt_st.internal_data_bus);
      nxt_st.hrdata = {24'h000000, rd};
      nxt_st.internal_data_bus = rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= CCR_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = st_ff.hrdata;
  assign hreadyout = st_ff.hreadyout;
  assign hresp = st_ff.hresp;

  // =====================================================================
  // control fan-out to comparators
  for (genvar c = 0; c < CCR_NUM_CH_REG; c++) begin : g_chan
    assign cmp_inv[2*c+1] = st_ff.regs[c][CCR_BIT_INV_ODD];
    assign cmp_hoff[2*c+1] = st_ff.regs[c][CCR_BIT_HOFF_ODD];
    assign cmp_en[2*c+1] = st_ff.regs[c][CCR_BIT_EN_ODD];
    assign cmp_inv[2*c] = st_ff.regs[c][CCR_BIT_INV_EVEN];
    assign cmp_hoff[2*c] = st_ff.regs[c][CCR_BIT_HOFF_EVEN];
    assign cmp_en[2*c] = st_ff.regs[c][CCR_BIT_EN_EVEN];
  end

  for (genvar b = 0; b < CCR_NUM_BANK; b++) begin : g_bank
    assign cmp_inv[CCR_BANK_BASE+b] = st_ff.regs[CCR_NUM_CH_REG+b][CCR_BIT_INV];
    assign cmp_hoff[CCR_BANK_BASE+b] = st_ff.regs[CCR_NUM_CH_REG+b][CCR_BIT_HOFF];
    assign cmp_en[CCR_BANK_BASE+b] = st_ff.regs[CCR_NUM_CH_REG+b][CCR_BIT_EN];
  end

  ccr_cmp_shape #(
    .N_CMP(CCR_NUM_CMP),
    .N_BANK(CCR_NUM_BANK),
    .BANK_BASE(CCR_BANK_BASE)
  ) u_shape (
    .hclk(hclk),
    .hresetn(hresetn),
    .cmp_raw(cmp_raw),
    .cmp_inv(cmp_inv),
    .cmp_en(cmp_en),
    .cmp_hoff(cmp_hoff),
    .cmp_out(cmp_out),
    .cmp_hysteresis_off(cmp_hysteresis_off),
    .bank_irq(bank_irq)
  );

  // =====================================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr_ch0;
    acc && hit && hwrite && (ridx == 4'h0);
  endsequence

  sequence s_wr_bank0;
    acc && hit && hwrite && (ridx == CCR_BANK_FIRST);
  endsequence

  sequence s_rd_bank0;
    acc && hit && !hwrite && (ridx == CCR_BANK_FIRST) && !st_ff.wr_pend;
  endsequence

  property p_ch_write;
    s_wr_ch0 ##1 1 |=> st_ff.regs[0] == ($past(hwdata[7:0]) & CCR_CH_MASK);
  endproperty
  a_ch_write: assert property (p_ch_write) else $error("channel write not stored");

  property p_bank_write;
    s_wr_bank0 ##1 1 |=> st_ff.regs[CCR_BANK_FIRST] == ($past(hwdata[7:0]) & CCR_BANK_MASK);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank write not stored");

  property p_bank_upper_bus;
    s_rd_bank0 |=> hrdata[7:4] == $past(st_ff.internal_data_bus[7:4])
      && hrdata[31:8] == 24'h000000;
  endproperty
  a_bank_upper_bus: assert property (p_bank_upper_bus) else $error("bank upper nibble wrong");

  property p_odd_invert;
    st_ff.regs[0][CCR_BIT_EN_ODD] |=> cmp_out[1] == ($past(cmp_raw[1])
      ^ $past(st_ff.regs[0][CCR_BIT_INV_ODD]));
  endproperty
  a_odd_invert: assert property (p_odd_invert) else $error("odd output not per invert");

  property p_odd_hoff;
    ##1 cmp_hysteresis_off[1] == $past(st_ff.regs[0][CCR_BIT_HOFF_ODD]);
  endproperty
  a_odd_hoff: assert property (p_odd_hoff) else $error("odd hysteresis control wrong");

  property p_odd_disabled;
    !st_ff.regs[0][CCR_BIT_EN_ODD] |=> !cmp_out[1];
  endproperty
  a_odd_disabled: assert property (p_odd_disabled) else $error("disabled odd not low");

  property p_even_invert;
    st_ff.regs[0][CCR_BIT_EN_EVEN] |=> cmp_out[0] == ($past(cmp_raw[0])
      ^ $past(st_ff.regs[0][CCR_BIT_INV_EVEN]));
  endproperty
  a_even_invert: assert property (p_even_invert) else $error("even output not per invert");

  property p_even_hoff;
    ##1 cmp_hysteresis_off[0] == $past(st_ff.regs[0][CCR_BIT_HOFF_EVEN]);
  endproperty
  a_even_hoff: assert property (p_even_hoff) else $error("even hysteresis control wrong");

  property p_even_disabled;
    !st_ff.regs[0][CCR_BIT_EN_EVEN] |=> !cmp_out[0];
  endproperty
  a_even_disabled: assert property (p_even_disabled) else $error("disabled even not low");

  property p_bank_invert;
    st_ff.regs[CCR_BANK_FIRST][CCR_BIT_EN] |=> cmp_out[CCR_BANK_BASE]
      == ($past(cmp_raw[CCR_BANK_BASE]) ^ $past(st_ff.regs[CCR_BANK_FIRST][CCR_BIT_INV]));
  endproperty
  a_bank_invert: assert property (p_bank_invert) else $error("bank output not per invert");

  property p_bank_hoff;
    ##1 cmp_hysteresis_off[CCR_BANK_BASE] == $past(st_ff.regs[CCR_BANK_FIRST][CCR_BIT_HOFF]);
  endproperty
  a_bank_hoff: assert property (p_bank_hoff) else $error("bank hysteresis control wrong");

  property p_bank_disabled;
    !st_ff.regs[CCR_BANK_FIRST][CCR_BIT_EN] |=> !cmp_out[CCR_BANK_BASE];
  endproperty
  a_bank_disabled: assert property (p_bank_disabled) else $error("disabled bank not low");

  property p_always_okay;
    hreadyout && hresp == CCR_HRESP_OKAY;
  endproperty
  a_always_okay: assert property (p_always_okay) else $error("slave not ready or not okay");

endmodule : ccr_regs

// ### verification/ccr_irq_sink.sv
// ccr_irq_sink: far-side consumer of the bank comparator event pulses
// assumes bank_irq comes from the block under test in the hclk domain
`timescale 1ns/10ps
module ccr_irq_sink
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // event pulses
  input wire logic [CCR_NUM_BANK-1:0] bank_irq,
  output logic [7:0] irq_count
);
  // one count per pulse, so a held pulse shows as extra counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_count <= 8'h00;
    end else begin
      irq_count <= irq_count + 8'($countones(bank_irq));
    end
  end
endmodule : ccr_irq_sink

// ### verification/ccr_regs_tb_top.sv
// ccr_regs_tb_top: self-checking bench for the comparator control bank
// assumes hready fed back from hreadyout, one 25 MHz clock
`timescale 1ns/10ps
module ccr_regs_tb_top
  import ccr_pkg::*;
;
  typedef struct packed {logic [3:0] k; logic [7:0] w; logic [7:0] e;} ccr_tb_row_s;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready;
  logic [13:0] cmp_raw, cmp_out, cmp_hoff;
  logic [5:0] bank_irq;
  logic [7:0] irq_count, c0;
  logic [7:0] m [CCR_NUM_REG];
  int num_errors, total_checks;
  ccr_tb_row_s rows [10] = '{'{4'h0, 8'hB1, 8'hB1}, '{4'h1, 8'h98, 8'h98},
    '{4'h2, 8'h23, 8'h23}, '{4'h3, 8'h9B, 8'h9B}, '{4'h4, 8'h09, 8'h09},
    '{4'h5, 8'h02, 8'h02}, '{4'h6, 8'h0B, 8'h0B}, '{4'h7, 8'h01, 8'h01},
    '{4'h8, 8'h08, 8'h08}, '{4'h9, 8'h0A, 8'h0A}};

  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  ccr_regs DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw), .cmp_out(cmp_out),
    .cmp_hysteresis_off(cmp_hoff), .bank_irq(bank_irq)
  );

  ccr_irq_sink sink (.hclk(hclk), .hresetn(hresetn), .bank_irq(bank_irq),
    .irq_count(irq_count));

  // ====================================================================
  // compare and verdict
  task automatic chk_reg(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk_reg

  task automatic chk_cmp(input string name, input logic [13:0] e, input logic [13:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk_cmp

  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // ====================================================================
  // bus master
  task automatic bus(input int k, input logic w, input logic [7:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h00000, CCR_IDX_CHANNEL_CMP_CTRL_0 + 10'(k), 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input int k, input logic [7:0] d);
    bus(k, 1'b1, d, q);
    if (k < 4) begin
      m[k] = d & CCR_CH_MASK;
    end else if (k < CCR_NUM_REG) begin
      m[k] = d & CCR_BANK_MASK;
    end
  endtask : wr

  task automatic rd(input int k, input logic [7:0] e);
    bus(k, 1'b0, 8'h00, q);
    chk_reg("hrdata", {24'h000000, e}, q);
  endtask : rd

  // ====================================================================
  // comparator path model
  task automatic chk_shape(input logic [13:0] raw);
    logic [13:0] eo;
    logic [13:0] eh;
    logic [7:0] r;
    int s;
    @(posedge hclk);
    cmp_raw <= raw;
    repeat (2) @(posedge hclk);
    #1;
    for (int i = 0; i < 14; i++) begin
      r = (i < 8) ? m[i/2] : m[i-4];
      s = (i < 8 && i % 2 == 1) ? 4 : 0;
      eh[i] = r[s+1];
      eo[i] = (raw[i] ^ r[s+3]) & r[s];
    end
    chk_cmp("cmp_out", eo, cmp_out);
    chk_cmp("cmp_hysteresis_off", eh, cmp_hoff);
  endtask : chk_shape

  // ====================================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    cmp_raw = 14'h0000;
    num_errors = 0;
    total_checks = 0;
    foreach (m[i]) m[i] = 8'h00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].k, rows[i].w);
      rd(rows[i].k, rows[i].e);
    end
    chk_shape(14'h0000);
    chk_shape(14'h3FFF);
    chk_shape(14'h1555);
    chk_shape(14'h2AAA);
    // upper bank bits follow the last bus byte, reads included
    wr(0, 8'hB8);
    rd(4, 8'hB9);
    rd(5, 8'hB2);
    // unmapped place: write lost, read zero
    bus(10, 1'b1, 8'h5A, q);
    rd(10, 8'h00);
    rd(3, 8'h9B);
    chk_reg("hresp", 32'h0, {31'h0, hresp});
    chk_reg("hreadyout", 32'h1, {31'h0, hreadyout});
    // bank event on a rising shaped output; even 0 disabled but inverted
    wr(4, 8'h01);
    chk_shape(14'h0000);
    c0 = irq_count;
    chk_shape(14'h0100);
    repeat (2) @(posedge hclk);
    chk_reg("irq_count", {24'h0, c0 + 8'h01}, {24'h0, irq_count});
    // second reset clears every register and output
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (m[i]) m[i] = 8'h00;
    for (int k = 0; k < 10; k++) begin
      rd(k, 8'h00);
    end
    chk_shape(14'h3FFF);
    print_verdict();
  end

  // ====================================================================
  // watchdog
  initial begin
    repeat (4000) @(posedge hclk);
    num_errors++;
    print_verdict();
  end
endmodule : ccr_regs_tb_top
